/* shared/edge_irq_pkg.sv */
// constants, register map and carrier types of the pin edge change interrupt unit
// Function
// - per-pin rising detector, armed by rise enable
// - per-pin falling detector, armed by fall enable
// - both enables set detects either polarity
// - enabled edge sets that pin's flag
// - enable off: flags still set, no request
// - request when any flag and enable set
// - summary flag is OR of all flags
// - writing zero clears flag, one keeps it
// - edge during flag write leaves flag set
// - enabled edge event wakes core from sleep
// - flag recorded before first instruction after wake
// - port A rise enables bits 5-0, rest zero
// - port A fall enables bits 5-0, rest zero
// - port A flags bits 5-0, rest zero
// - port B rise enables bits 7-4 only
// - all enable and flag bits reset zero
// - disable bit stops edge detection and request
// - port B fall enables bits 7-4 only
// - port B flags bits 7-4, hardware set
package edge_irq_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NPIN_A = 6;
    localparam int unsigned NPIN_B = 4;
    localparam int unsigned NPIN = NPIN_A + NPIN_B;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_PA_RISE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PA_FALL = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_PA_FLAGS = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_PB_RISE = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_PB_FALL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_PB_FLAGS = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h7;

    // field positions
    localparam int unsigned PB_FIELD_LSB = 4;
    localparam int unsigned CTRL_IRQ_EN_BIT = 0;
    localparam int unsigned CTRL_DISABLE_BIT = 1;
    localparam int unsigned STATUS_SUMMARY_BIT = 0;

    // reset values
    localparam logic [NPIN-1:0] RST_PIN_VEC = 10'h000;
    localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;
    localparam logic [1:0] RST_WARM = 2'h0;
    // cycles until sync stage and previous sample both hold real pin data
    localparam logic [1:0] WARM_DONE = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef struct packed {
        logic [NPIN-1:0] sync1;
        logic [NPIN-1:0] sync2;
        logic [NPIN-1:0] prev;
        logic [NPIN-1:0] rise_en;
        logic [NPIN-1:0] fall_en;
        logic [NPIN-1:0] flags;
        logic irq_en;
        logic unit_dis;
        logic [1:0] warm;
        logic [DATA_W-1:0] rdata;
        logic summary;
        logic irq;
        logic wake;
    } edge_state_s;

endpackage

/* core/pin_edge_change_interrupt.sv */
// pin edge change interrupt unit: edge detect, flags, summary, request and wake
`timescale 1ns/1ps
`default_nettype none

module pin_edge_change_interrupt
    import edge_irq_pkg::*;
#(
    parameter bit PORTB_PRESENT = 1'b1
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [NPIN_A-1:0] i_porta_pin,
    input wire logic [NPIN_B-1:0] i_portb_pin,
    input wire logic i_sleep,
    input wire bus_req_s i_bus,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_summary_flag,
    output logic o_irq,
    output logic o_wake
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    // port B bits vanish on the small variant
    localparam logic [NPIN-1:0] PIN_MASK = {{NPIN_B{PORTB_PRESENT}}, {NPIN_A{1'b1}}};

    edge_state_s s_q;
    edge_state_s s_d;
    logic [NPIN-1:0] pins;
    logic armed;
    logic [NPIN-1:0] rise_set;
    logic [NPIN-1:0] fall_set;
    logic [NPIN-1:0] set_v;
    logic [NPIN-1:0] keep_mask;

    // port B pins sit at bits 9..6, above port A pins 5..0
    assign pins = {i_portb_pin, i_porta_pin};

    ////////////////////////////////////////////////////////////////////////////
    // next state

    // one pass: sync, detect, register writes, flags, request, read data
    always_comb begin
        s_d = s_q;
        armed = 1'b0;
        rise_set = RST_PIN_VEC;
        fall_set = RST_PIN_VEC;
        set_v = RST_PIN_VEC;
        keep_mask = {NPIN{1'b1}};

        // two flops before any logic, then one sample of history
        s_d.sync1 = pins;
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        if (s_q.warm != WARM_DONE) begin
            s_d.warm = s_q.warm + 2'h1;
        end

        // no detection until history is real, so a high pin at reset is no edge
        armed = (s_q.warm == WARM_DONE) && !s_q.unit_dis;
        rise_set = s_q.sync2 & ~s_q.prev & s_q.rise_en & PIN_MASK & {NPIN{armed}};
        fall_set = ~s_q.sync2 & s_q.prev & s_q.fall_en & PIN_MASK & {NPIN{armed}};
        set_v = rise_set | fall_set;

        // register writes; unimplemented bits are never stored
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                OFS_PA_RISE: s_d.rise_en[NPIN_A-1:0] = i_bus.wdata[NPIN_A-1:0];
                OFS_PA_FALL: s_d.fall_en[NPIN_A-1:0] = i_bus.wdata[NPIN_A-1:0];
                OFS_PB_RISE: begin
                    s_d.rise_en[NPIN-1:NPIN_A] = i_bus.wdata[DATA_W-1:PB_FIELD_LSB]
                        & PIN_MASK[NPIN-1:NPIN_A];
                end
                OFS_PB_FALL: begin
                    s_d.fall_en[NPIN-1:NPIN_A] = i_bus.wdata[DATA_W-1:PB_FIELD_LSB]
                        & PIN_MASK[NPIN-1:NPIN_A];
                end
                OFS_PA_FLAGS: keep_mask[NPIN_A-1:0] = i_bus.wdata[NPIN_A-1:0];
                OFS_PB_FLAGS: keep_mask[NPIN-1:NPIN_A] = i_bus.wdata[DATA_W-1:PB_FIELD_LSB];
                OFS_CTRL: begin
                    s_d.irq_en = i_bus.wdata[CTRL_IRQ_EN_BIT];
                    s_d.unit_dis = i_bus.wdata[CTRL_DISABLE_BIT];
                end
                default: ;
            endcase
        end

        // a write can only clear; a new edge in the same cycle wins
        s_d.flags = ((s_q.flags & keep_mask) | set_v) & PIN_MASK;

        // flag and request load on the same edge, so the flag is never late
        s_d.summary = |s_d.flags;
        s_d.irq = s_d.summary && s_d.irq_en && !s_d.unit_dis;
        s_d.wake = s_d.irq && i_sleep;

        // read data only in the cycle after the strobe, zero elsewhere
        s_d.rdata = RST_RDATA;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                OFS_PA_RISE: s_d.rdata = {2'h0, s_q.rise_en[NPIN_A-1:0]};
                OFS_PA_FALL: s_d.rdata = {2'h0, s_q.fall_en[NPIN_A-1:0]};
                OFS_PA_FLAGS: s_d.rdata = {2'h0, s_q.flags[NPIN_A-1:0]};
                OFS_PB_RISE: s_d.rdata = {s_q.rise_en[NPIN-1:NPIN_A], 4'h0};
                OFS_PB_FALL: s_d.rdata = {s_q.fall_en[NPIN-1:NPIN_A], 4'h0};
                OFS_PB_FLAGS: s_d.rdata = {s_q.flags[NPIN-1:NPIN_A], 4'h0};
                OFS_CTRL: begin
                    s_d.rdata[CTRL_IRQ_EN_BIT] = s_q.irq_en;
                    s_d.rdata[CTRL_DISABLE_BIT] = s_q.unit_dis;
                end
                OFS_STATUS: s_d.rdata[STATUS_SUMMARY_BIT] = s_q.summary;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // everything clears on any reset
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_summary_flag = s_q.summary;
    assign o_irq = s_q.irq;
    assign o_wake = s_q.wake;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    a_rise_sets_flag: assert property (
        (rise_set != RST_PIN_VEC) |=> ((s_q.flags & $past(rise_set)) == $past(rise_set))
    ) else $error("rising edge did not set its flag");

    a_fall_sets_flag: assert property (
        (fall_set != RST_PIN_VEC) |=> ((s_q.flags & $past(fall_set)) == $past(fall_set))
    ) else $error("falling edge did not set its flag");

    a_flag_needs_cause: assert property (
        ((s_q.flags & ~$past(s_q.flags)) & ~$past(set_v)) == RST_PIN_VEC
    ) else $error("flag set without an enabled edge");

    a_irq_gated: assert property (
        o_irq == (o_summary_flag && s_q.irq_en && !s_q.unit_dis)
    ) else $error("request does not match flags and enable");

    a_summary_or: assert property (
        o_summary_flag == (|s_q.flags)
    ) else $error("summary flag is not the OR of all flags");

    a_write_clears: assert property (
        (i_bus.wr && i_bus.addr == OFS_PA_FLAGS && set_v == RST_PIN_VEC)
        |=> s_q.flags[NPIN_A-1:0]
            == ($past(s_q.flags[NPIN_A-1:0]) & $past(i_bus.wdata[NPIN_A-1:0]))
    ) else $error("flag write did not clear as written");

    a_set_beats_clear: assert property (
        (i_bus.wr && i_bus.addr == OFS_PA_FLAGS && set_v != RST_PIN_VEC)
        |=> ((s_q.flags & $past(set_v)) == $past(set_v))
    ) else $error("edge lost during flag write");

    a_wake_with_flag: assert property (
        o_wake |-> (o_irq && o_summary_flag && $past(i_sleep))
    ) else $error("wake without recorded flag");

    a_disable_blocks: assert property (
        s_q.unit_dis |=> ((s_q.flags & ~$past(s_q.flags)) == RST_PIN_VEC)
    ) else $error("disabled unit set a flag");

    a_pa_upper_zero: assert property (
        (i_bus.rd && i_bus.addr == OFS_PA_RISE) |=> o_rdata[DATA_W-1:NPIN_A] == 2'h0
    ) else $error("port A unimplemented bits read nonzero");

    ////////////////////////////////////////////////////////////////////////////
    // detector checks

    // an edge only counts where the pin's own enable is set
    a_rise_needs_enable: assert property (
        (rise_set & ~s_q.rise_en) == RST_PIN_VEC
    ) else $error("rising edge taken without its enable");

    // same for the falling side
    a_fall_needs_enable: assert property (
        (fall_set & ~s_q.fall_en) == RST_PIN_VEC
    ) else $error("falling edge taken without its enable");

    // with both enables a pin reports any change of level
    a_either_polarity: assert property (
        (set_v & s_q.rise_en & s_q.fall_en)
            == ((s_q.sync2 ^ s_q.prev) & s_q.rise_en & s_q.fall_en & PIN_MASK & {NPIN{armed}})
    ) else $error("pin with both enables missed a change");

    // no edge without two differing samples
    a_edge_is_change: assert property (
        (set_v & ~(s_q.sync2 ^ s_q.prev)) == RST_PIN_VEC
    ) else $error("edge seen on a steady pin");

    // history not yet real, so nothing may count
    a_no_edge_warming: assert property (
        (s_q.warm != WARM_DONE) |-> (set_v == RST_PIN_VEC)
    ) else $error("edge detected before history was valid");

    // second stage only ever copies the first
    a_sync_stage_two: assert property (
        s_q.sync2 == $past(s_q.sync1)
    ) else $error("second sync stage skipped a sample");

    // previous sample trails the synchronised one by a cycle
    a_prev_sample: assert property (
        s_q.prev == $past(s_q.sync2)
    ) else $error("previous sample out of step");

    // a disabled unit detects nothing at all
    a_disabled_no_edge: assert property (
        s_q.unit_dis |-> (set_v == RST_PIN_VEC)
    ) else $error("disabled unit detected an edge");

    ////////////////////////////////////////////////////////////////////////////
    // flag checks

    // any detected edge lands in its flag, whatever the bus does
    a_set_wins_any: assert property (
        (set_v != RST_PIN_VEC) |=> ((s_q.flags & $past(set_v)) == $past(set_v))
    ) else $error("detected edge did not reach its flag");

    // a flag only drops through a write to its own register
    a_flag_falls_on_write: assert property (
        (($past(s_q.flags) & ~s_q.flags) != RST_PIN_VEC)
        |-> ($past(i_bus.wr)
            && ($past(i_bus.addr) == OFS_PA_FLAGS || $past(i_bus.addr) == OFS_PB_FLAGS))
    ) else $error("flag dropped without a flag write");

    // port B flags clear only where a zero is written
    a_pb_write_clears: assert property (
        (i_bus.wr && i_bus.addr == OFS_PB_FLAGS && set_v == RST_PIN_VEC)
        |=> s_q.flags[NPIN-1:NPIN_A]
            == ($past(s_q.flags[NPIN-1:NPIN_A]) & $past(i_bus.wdata[DATA_W-1:PB_FIELD_LSB]))
    ) else $error("port B flag write did not clear as written");

    // edge during a port B flag write survives the write
    a_pb_set_beats_clear: assert property (
        (i_bus.wr && i_bus.addr == OFS_PB_FLAGS && set_v != RST_PIN_VEC)
        |=> ((s_q.flags & $past(set_v)) == $past(set_v))
    ) else $error("edge lost during port B flag write");

    // absent pins keep no enable and no flag
    a_absent_pins_quiet: assert property (
        ((s_q.rise_en | s_q.fall_en | s_q.flags) & ~PIN_MASK) == RST_PIN_VEC
    ) else $error("absent pin holds an enable or flag");

    ////////////////////////////////////////////////////////////////////////////
    // request and wake checks

    // no request without a flag behind it
    a_irq_needs_flag: assert property (
        o_irq |-> o_summary_flag
    ) else $error("request without any flag");

    // enabled edge raises the request one cycle on
    a_irq_follows_edge: assert property (
        (set_v != RST_PIN_VEC && s_q.irq_en && !s_q.unit_dis
            && !(i_bus.wr && i_bus.addr == OFS_CTRL))
        |=> o_irq
    ) else $error("enabled edge raised no request");

    // shared enable off: flag and summary still set, request stays low
    a_quiet_flags_only: assert property (
        (set_v != RST_PIN_VEC && !s_q.irq_en && !(i_bus.wr && i_bus.addr == OFS_CTRL))
        |=> (o_summary_flag && !o_irq)
    ) else $error("quiet unit lost a flag or raised a request");

    // shared enable off holds the request down
    a_no_irq_when_off: assert property (
        !s_q.irq_en |-> !o_irq
    ) else $error("request with shared enable off");

    // disable bit holds the request down
    a_disable_no_irq: assert property (
        s_q.unit_dis |-> !o_irq
    ) else $error("request from a disabled unit");

    // wake only with the shared enable set
    a_wake_needs_enable: assert property (
        o_wake |-> s_q.irq_en
    ) else $error("wake with shared enable off");

    // wake is the request seen while the core sleeps
    a_wake_in_sleep: assert property (
        o_wake == (o_irq && $past(i_sleep))
    ) else $error("wake does not follow request in sleep");

    // the flag is already there when wake first rises
    a_flag_before_wake: assert property (
        $rose(o_wake) |-> (s_q.flags != RST_PIN_VEC)
    ) else $error("wake rose before its flag");

    ////////////////////////////////////////////////////////////////////////////
    // register checks

    // port A rise enables take the written bits
    a_pa_rise_write: assert property (
        (i_bus.wr && i_bus.addr == OFS_PA_RISE)
        |=> s_q.rise_en[NPIN_A-1:0] == $past(i_bus.wdata[NPIN_A-1:0])
    ) else $error("port A rise enable write lost");

    // port A fall enables take the written bits
    a_pa_fall_write: assert property (
        (i_bus.wr && i_bus.addr == OFS_PA_FALL)
        |=> s_q.fall_en[NPIN_A-1:0] == $past(i_bus.wdata[NPIN_A-1:0])
    ) else $error("port A fall enable write lost");

    // port B rise enables from the upper nibble only
    a_pb_rise_write: assert property (
        (i_bus.wr && i_bus.addr == OFS_PB_RISE)
        |=> s_q.rise_en[NPIN-1:NPIN_A]
            == ($past(i_bus.wdata[DATA_W-1:PB_FIELD_LSB]) & PIN_MASK[NPIN-1:NPIN_A])
    ) else $error("port B rise enable write lost");

    // port B fall enables from the upper nibble only
    a_pb_fall_write: assert property (
        (i_bus.wr && i_bus.addr == OFS_PB_FALL)
        |=> s_q.fall_en[NPIN-1:NPIN_A]
            == ($past(i_bus.wdata[DATA_W-1:PB_FIELD_LSB]) & PIN_MASK[NPIN-1:NPIN_A])
    ) else $error("port B fall enable write lost");

    // control bits take the written values
    a_ctrl_write: assert property (
        (i_bus.wr && i_bus.addr == OFS_CTRL)
        |=> (s_q.unit_dis == $past(i_bus.wdata[CTRL_DISABLE_BIT])
            && s_q.irq_en == $past(i_bus.wdata[CTRL_IRQ_EN_BIT]))
    ) else $error("control write lost");

    // unimplemented top bits of port A fall enables
    a_pa_fall_upper_zero: assert property (
        (i_bus.rd && i_bus.addr == OFS_PA_FALL) |=> o_rdata[DATA_W-1:NPIN_A] == 2'h0
    ) else $error("port A fall enable top bits read nonzero");

    // unimplemented top bits of port A flags
    a_pa_flags_upper_zero: assert property (
        (i_bus.rd && i_bus.addr == OFS_PA_FLAGS) |=> o_rdata[DATA_W-1:NPIN_A] == 2'h0
    ) else $error("port A flag top bits read nonzero");

    // port A flags read back as held
    a_pa_flags_readback: assert property (
        (i_bus.rd && i_bus.addr == OFS_PA_FLAGS)
        |=> o_rdata[NPIN_A-1:0] == $past(s_q.flags[NPIN_A-1:0])
    ) else $error("port A flags read back wrong");

    // unimplemented low nibble of port B rise enables
    a_pb_rise_lower_zero: assert property (
        (i_bus.rd && i_bus.addr == OFS_PB_RISE) |=> o_rdata[PB_FIELD_LSB-1:0] == 4'h0
    ) else $error("port B rise enable low bits read nonzero");

    // unimplemented low nibble of port B fall enables
    a_pb_fall_lower_zero: assert property (
        (i_bus.rd && i_bus.addr == OFS_PB_FALL) |=> o_rdata[PB_FIELD_LSB-1:0] == 4'h0
    ) else $error("port B fall enable low bits read nonzero");

    // unimplemented low nibble of port B flags
    a_pb_flags_lower_zero: assert property (
        (i_bus.rd && i_bus.addr == OFS_PB_FLAGS) |=> o_rdata[PB_FIELD_LSB-1:0] == 4'h0
    ) else $error("port B flag low bits read nonzero");

    // summary visible to software through the status register
    a_status_summary: assert property (
        (i_bus.rd && i_bus.addr == OFS_STATUS)
        |=> o_rdata[STATUS_SUMMARY_BIT] == $past(o_summary_flag)
    ) else $error("status read does not show the summary");

    // state sits at zero while reset holds, from its second edge on
    a_reset_clears: assert property (
        disable iff (1'b0)
        (i_rst && $past(i_rst)) |-> (o_rdata == RST_RDATA && !o_irq && !o_summary_flag
            && !o_wake && s_q.flags == RST_PIN_VEC && s_q.rise_en == RST_PIN_VEC)
    ) else $error("state not cleared by reset");

endmodule // pin_edge_change_interrupt

`default_nettype wire

/* testbench/pin_source.sv */
// pin source model standing on the port pins of the edge unit
`timescale 1ns/1ps
`default_nettype none
module pin_source (
    input wire logic i_clk_sys,
    input wire logic [5:0] i_lvl_a,
    input wire logic [3:0] i_lvl_b,
    output logic [5:0] o_porta_pin,
    output logic [3:0] o_portb_pin
);
    // pins move just after an edge, so no sample lands on a change
    always_ff @(posedge i_clk_sys) begin
        o_porta_pin <= i_lvl_a;
        o_portb_pin <= i_lvl_b;
    end
endmodule // pin_source
`default_nettype wire

/* testbench/pin_edge_change_interrupt_tb.sv */
// self-checking bench of the pin edge change interrupt unit
`timescale 1ns/1ps
`default_nettype none
module pin_edge_change_interrupt_tb import edge_irq_pkg::*; ;
    logic i_clk_sys, i_rst, i_sleep;
    bus_req_s i_bus;
    logic [5:0] lvl_a, pa;
    logic [3:0] lvl_b, pb;
    logic [7:0] o_rdata;
    logic o_summary_flag, o_irq, o_wake;
    int miscompares = 0;
    int num_checks = 0;
    pin_source ps (.i_clk_sys(i_clk_sys), .i_lvl_a(lvl_a), .i_lvl_b(lvl_b),
        .o_porta_pin(pa), .o_portb_pin(pb));
    pin_edge_change_interrupt uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_porta_pin(pa),
        .i_portb_pin(pb), .i_sleep(i_sleep), .i_bus(i_bus), .o_rdata(o_rdata),
        .o_summary_flag(o_summary_flag), .o_irq(o_irq), .o_wake(o_wake));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // one write cycle, strobe dropped at the next edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk_sys);
        i_bus.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk_sys);
        i_bus.rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), o_rdata, exp);
    endtask
    // pin levels, then enough edges for sync and compare
    task automatic move(input logic [5:0] a, input logic [3:0] b);
        @(posedge i_clk_sys);
        lvl_a <= a;
        lvl_b <= b;
        repeat (5) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic outs(input logic irq, input logic sum, input logic wake);
        chk("irq", {7'h0, o_irq}, {7'h0, irq});
        chk("summary", {7'h0, o_summary_flag}, {7'h0, sum});
        chk("wake", {7'h0, o_wake}, {7'h0, wake});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_fields();
        logic [7:0] fmask [0:7] = '{8'h3f, 8'h3f, 8'h00, 8'hf0, 8'hf0, 8'h00, 8'h03, 8'h00};
        for (int a = 0; a < 9; a++) rd(4'(a), 8'h00);
        for (int a = 0; a < 8; a++) begin
            wr(4'(a), 8'hff);
            rd(4'(a), fmask[a]);
        end
        for (int a = 0; a < 6; a++) wr(4'(a), 8'h00);
        wr(4'h6, 8'h01);
    endtask
    // rise-only (its fall not seen), both, with masking clears
    task automatic t_edges();
        wr(4'h0, 8'h05);
        wr(4'h1, 8'h06);
        move(6'h01, 4'h0);
        rd(4'h2, 8'h01);
        outs(1'b1, 1'b1, 1'b0);
        rd(4'h7, 8'h01);
        move(6'h00, 4'h0);
        rd(4'h2, 8'h01);
        wr(4'h2, 8'hff ^ 8'h01);
        rd(4'h2, 8'h00);
        outs(1'b0, 1'b0, 1'b0);
        move(6'h04, 4'h0);
        rd(4'h2, 8'h04);
        wr(4'h2, 8'hfb);
        move(6'h00, 4'h0);
        rd(4'h2, 8'h04);
        wr(4'h2, 8'hfb);
    endtask
    // flags still set with the shared enable off, then port B
    task automatic t_quiet_b();
        wr(4'h6, 8'h00);
        move(6'h01, 4'h0);
        rd(4'h2, 8'h01);
        outs(1'b0, 1'b1, 1'b0);
        wr(4'h2, 8'hfe);
        wr(4'h6, 8'h01);
        wr(4'h3, 8'h10);
        move(6'h01, 4'h1);
        rd(4'h5, 8'h10);
        outs(1'b1, 1'b1, 1'b0);
        wr(4'h5, 8'hef);
        wr(4'h4, 8'h10);
        move(6'h01, 4'h0);
        rd(4'h5, 8'h10);
        move(6'h01, 4'h1);
        wr(4'h5, 8'hef);
    endtask
    // edge lands in the very cycle that clears the flag
    task automatic t_race_sleep();
        move(6'h00, 4'h1);
        @(posedge i_clk_sys);
        lvl_a <= 6'h01;
        repeat (2) @(posedge i_clk_sys);
        wr(4'h2, 8'h00);
        rd(4'h2, 8'h01);
        wr(4'h2, 8'hfe);
        i_sleep <= 1'b1;
        move(6'h00, 4'h1);
        move(6'h01, 4'h1);
        outs(1'b1, 1'b1, 1'b1);
        rd(4'h2, 8'h01);
        wr(4'h2, 8'hfe);
        @(posedge i_clk_sys);
        i_sleep <= 1'b0;
        wr(4'h6, 8'h03);
        move(6'h00, 4'h1);
        move(6'h01, 4'h1);
        rd(4'h2, 8'h00);
        outs(1'b0, 1'b0, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // 250 MHz system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    // watchdog, about twenty-four times the expected run
    initial begin
        #20000;
        miscompares++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        i_rst = 1'b1;
        i_sleep = 1'b0;
        i_bus = '0;
        lvl_a = 6'h00;
        lvl_b = 4'h0;
        repeat (3) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (5) @(posedge i_clk_sys);
        t_fields();
        t_edges();
        t_quiet_b();
        t_race_sleep();
        tally_and_finish();
    end
endmodule // pin_edge_change_interrupt_tb
`default_nettype wire
